// ### rtl/csr_defines.svh
// constants of the charger status register bank: offsets, resets, field positions
// assumes inclusion by every file that uses its macros; definitions only
//
// Summary of operation
// R1: flags bit 7 is high while forward-mode input current regulation is active.
// R2: flags bit 6 is high while forward-mode input voltage regulation is active.
// R3: flags bit 5 is high once the bus watchdog timer has expired.
// R4: flags bit 4 is high when poor-source detection finds a weak adaptor.
// R5: flags bit 3 is high while the input is in power-good condition.
// R6: flags bit 2 is high while the second input source is present.
// R7: flags bit 1 is high while the first input source is present.
// R8: flags bit 0 is high while the bus supply is present.
// R9: flags register sits at 1Bh, read-only, resets to zero.
// R10: summary register at 1Ch: charge state 7-5, supply type 4-1, detect done 0.
// R11: bits follow their conditions; reads have no side effect; writes are ignored.
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define CSR_FLAGS_OFS 8'h1B
`define CSR_SUMMARY_OFS 8'h1C
`define CSR_FLAGS_RST 8'h00
`define CSR_SUMMARY_RST 8'h00
`define CSR_UNMAPPED_VAL 8'h00

// ****************************************
// field positions
// ****************************************
`define CSR_IIN_REG_BIT 7
`define CSR_VIN_REG_BIT 6
`define CSR_WDOG_BIT 5
`define CSR_WEAK_BIT 4
`define CSR_PGOOD_BIT 3
`define CSR_SRC2_BIT 2
`define CSR_SRC1_BIT 1
`define CSR_VBUS_BIT 0
`define CSR_CHG_MSB 7
`define CSR_CHG_LSB 5
`define CSR_TYPE_MSB 4
`define CSR_TYPE_LSB 1
`define CSR_DONE_BIT 0

// ****************************************
// serial port
// ****************************************
`define CSR_DEV_ADDR 7'h2A
`define CSR_BYTE_BITS 4'h8
`define CSR_TX_LAST 4'h7
`define CSR_SYNC_W 18

`endif

// ### rtl/csr_pkg.sv
// types of the charger status register bank
// assumes no other package; used as csr_pkg::name
`default_nettype none
package csr_pkg;

  // condition flags, msb first as in the flags register
  typedef struct packed {
    logic input_current_regulating_flag;
    logic input_voltage_regulating_flag;
    logic watchdog_expired_flag;
    logic weak_adaptor_flag;
    logic input_power_good_flag;
    logic second_source_present_flag;
    logic first_source_present_flag;
    logic bus_supply_present_flag;
  } csr_flags_t;

  // charge state summary, msb first
  typedef struct packed {
    logic [2:0] charge_state_field;
    logic [3:0] bus_supply_type_field;
    logic charger_detect_done_flag;
  } csr_summary_t;

  // serial slave states, one-hot
  typedef enum logic [4:0] {
    CSR_ST_IDLE = 5'h01,
    CSR_ST_RX = 5'h02,
    CSR_ST_ACK = 5'h04,
    CSR_ST_TX = 5'h08,
    CSR_ST_TXACK = 5'h10
  } csr_state_t;

endpackage
`default_nettype wire

// ### rtl/csr_sync.sv
// two-stage synchroniser for pins and analogue detector levels
// assumes i_rst_n is already released synchronously to i_clk
`timescale 1ns/1ns
`default_nettype none
`include "csr_defines.svh"
module csr_sync (
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // synchronous-release reset
  input wire logic [`CSR_SYNC_W-1:0] i_async, // levels from outside
  output logic [`CSR_SYNC_W-1:0] o_sync // synchronised levels
);

  logic [`CSR_SYNC_W-1:0] meta_ff;
  logic [`CSR_SYNC_W-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule
`default_nettype wire

// ### rtl/csr_top.sv
// charger status register bank with its two-wire serial slave port
// assumes open-drain bus resolved outside; detector levels are asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "csr_defines.svh"
module csr_top (
  input wire logic i_clk, // core clock, 100 MHz
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_scl, // serial clock pin
  input wire logic i_sda, // serial data pin level
  output logic o_sda_o, // serial data drive value
  output logic o_sda_oe, // serial data drive enable
  input wire csr_pkg::csr_flags_t i_flags, // detector conditions
  input wire csr_pkg::csr_summary_t i_summary, // charge state conditions
  output logic [7:0] o_charger_flags, // flags register copy
  output logic [7:0] o_charge_state_summary // summary register copy
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_n_ff;

  // assert at once, release after two edges
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [`CSR_SYNC_W-1:0] sync_q;
  logic scl_s;
  logic sda_s;
  csr_pkg::csr_flags_t flags_s;
  csr_pkg::csr_summary_t summ_s;

  csr_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n_ff),
    .i_async({i_scl, i_sda, i_flags, i_summary}),
    .o_sync(sync_q)
  );

  // split the synchronised vector
  assign scl_s = sync_q[17];
  assign sda_s = sync_q[16];
  assign flags_s = sync_q[15:8];
  assign summ_s = sync_q[7:0];

  // ****************************************
  // status registers
  // ****************************************
  logic [7:0] flags_ff;
  logic [7:0] summary_ff;
  logic [7:0] nxt_flags;
  logic [7:0] nxt_summary;

  // each bit tracks its condition every cycle
  always_comb begin
    nxt_flags = flags_ff;
    nxt_summary = summary_ff;
    nxt_flags[`CSR_IIN_REG_BIT] = flags_s.input_current_regulating_flag; // R1
    nxt_flags[`CSR_VIN_REG_BIT] = flags_s.input_voltage_regulating_flag; // R2
    nxt_flags[`CSR_WDOG_BIT] = flags_s.watchdog_expired_flag; // R3
    nxt_flags[`CSR_WEAK_BIT] = flags_s.weak_adaptor_flag; // R4
    nxt_flags[`CSR_PGOOD_BIT] = flags_s.input_power_good_flag; // R5
    nxt_flags[`CSR_SRC2_BIT] = flags_s.second_source_present_flag; // R6
    nxt_flags[`CSR_SRC1_BIT] = flags_s.first_source_present_flag; // R7
    nxt_flags[`CSR_VBUS_BIT] = flags_s.bus_supply_present_flag; // R8
    nxt_summary[`CSR_CHG_MSB:`CSR_CHG_LSB] = summ_s.charge_state_field; // R10
    nxt_summary[`CSR_TYPE_MSB:`CSR_TYPE_LSB] = summ_s.bus_supply_type_field; // R10
    nxt_summary[`CSR_DONE_BIT] = summ_s.charger_detect_done_flag; // R10
  end

  // status storage, zero at reset
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      flags_ff <= `CSR_FLAGS_RST; // R9
      summary_ff <= `CSR_SUMMARY_RST; // R10
    end else begin
      flags_ff <= nxt_flags; // R11
      summary_ff <= nxt_summary; // R11
    end
  end

  assign o_charger_flags = flags_ff;
  assign o_charge_state_summary = summary_ff;

  // ****************************************
  // read decode
  // ****************************************
  // register contents at an offset, zero when unmapped
  function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic [7:0] flg,
                                          input logic [7:0] sum);
    logic [7:0] val;
    val = `CSR_UNMAPPED_VAL;
    if (ofs == `CSR_FLAGS_OFS) begin
      val = flg; // R9
    end else if (ofs == `CSR_SUMMARY_OFS) begin
      val = sum; // R10
    end
    return val;
  endfunction

  // ****************************************
  // serial slave
  // ****************************************
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  csr_pkg::csr_state_t state_ff;
  csr_pkg::csr_state_t nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [1:0] byte_idx_ff;
  logic [1:0] nxt_byte_idx;
  logic rw_ff;
  logic nxt_rw;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic ack_ok_ff;
  logic nxt_ack_ok;
  logic [7:0] rd_byte;
  logic [7:0] rd_next;
  logic [7:0] ptr_inc;

  // bus events from the synchronised pins
  assign scl_rise = scl_s & ~scl_prev_ff;
  assign scl_fall = ~scl_s & scl_prev_ff;
  assign bus_start = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign bus_stop = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  assign ptr_inc = ptr_ff + 8'h01;
  assign rd_byte = reg_read(ptr_ff, flags_ff, summary_ff); // R11
  assign rd_next = reg_read(ptr_inc, flags_ff, summary_ff); // R11

  // slave sequencing: address, pointer, data bytes
  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_byte_idx = byte_idx_ff;
    nxt_rw = rw_ff;
    nxt_ptr = ptr_ff;
    nxt_shift = shift_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_ack_ok = ack_ok_ff;
    if (bus_stop) begin
      nxt_state = csr_pkg::CSR_ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (bus_start) begin
      nxt_state = csr_pkg::CSR_ST_RX;
      nxt_bit_cnt = 4'h0;
      nxt_byte_idx = 2'h0;
      nxt_sda_oe = 1'b0;
    end else begin
      unique case (state_ff)
        csr_pkg::CSR_ST_IDLE: begin
          nxt_sda_oe = 1'b0;
        end
        csr_pkg::CSR_ST_RX: begin
          if (scl_rise && bit_cnt_ff != `CSR_BYTE_BITS) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == `CSR_BYTE_BITS) begin
            nxt_bit_cnt = 4'h0;
            if (byte_idx_ff == 2'h0) begin
              if (shift_ff[7:1] == `CSR_DEV_ADDR) begin
                nxt_rw = shift_ff[0];
                nxt_sda_oe = 1'b1;
                nxt_state = csr_pkg::CSR_ST_ACK;
              end else begin
                nxt_state = csr_pkg::CSR_ST_IDLE;
              end
            end else begin
              if (byte_idx_ff == 2'h1) begin
                nxt_ptr = shift_ff;
              end
              nxt_sda_oe = 1'b1; // later data bytes acked, no effect: R11
              nxt_state = csr_pkg::CSR_ST_ACK;
            end
            if (byte_idx_ff != 2'h2) begin
              nxt_byte_idx = byte_idx_ff + 2'h1;
            end
          end
        end
        csr_pkg::CSR_ST_ACK: begin
          if (scl_fall) begin
            nxt_bit_cnt = 4'h0;
            if (rw_ff) begin
              nxt_shift = rd_byte;
              nxt_sda_oe = ~rd_byte[7];
              nxt_state = csr_pkg::CSR_ST_TX;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_state = csr_pkg::CSR_ST_RX;
            end
          end
        end
        csr_pkg::CSR_ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_ff == `CSR_TX_LAST) begin
              nxt_sda_oe = 1'b0;
              nxt_state = csr_pkg::CSR_ST_TXACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
              nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
          end
        end
        csr_pkg::CSR_ST_TXACK: begin
          if (scl_rise) begin
            nxt_ack_ok = ~sda_s;
          end else if (scl_fall) begin
            if (ack_ok_ff) begin
              nxt_ptr = ptr_inc;
              nxt_shift = rd_next;
              nxt_sda_oe = ~rd_next[7];
              nxt_bit_cnt = 4'h0;
              nxt_state = csr_pkg::CSR_ST_TX;
            end else begin
              nxt_state = csr_pkg::CSR_ST_IDLE;
            end
          end
        end
        default: begin
          nxt_state = csr_pkg::CSR_ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // slave storage
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      state_ff <= csr_pkg::CSR_ST_IDLE;
      bit_cnt_ff <= 4'h0;
      byte_idx_ff <= 2'h0;
      rw_ff <= 1'b0;
      ptr_ff <= 8'h00;
      shift_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      byte_idx_ff <= nxt_byte_idx;
      rw_ff <= nxt_rw;
      ptr_ff <= nxt_ptr;
      shift_ff <= nxt_shift;
      sda_oe_ff <= nxt_sda_oe;
      ack_ok_ff <= nxt_ack_ok;
    end
  end

  // open drain: only ever pulls low
  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_ff;

endmodule
`default_nettype wire

// ### verification/csr_host_model.sv
// two-wire bus master standing in for the host controller
// assumes open-drain wire resolved by the bench, about 1 us per clock phase
`timescale 1ns/1ns
`default_nettype none
`include "csr_defines.svh"
module csr_host_model (
  input wire logic i_clk, // core clock
  input wire logic i_sda, // resolved data wire
  output var logic o_scl, // serial clock
  output var logic o_sda_low // high pulls data low
);
  // idle bus: clock high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // ****
  // bus cycles
  // ****
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one bit: data moves in low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    wt(25);
    o_sda_low <= !b;
    wt(75);
    o_scl <= 1'b1;
    wt(50);
    r = i_sda;
    wt(50);
    o_scl <= 1'b0;
  endtask
  task automatic start();
    wt(25);
    o_sda_low <= 1'b0;
    wt(75);
    o_scl <= 1'b1;
    wt(100);
    o_sda_low <= 1'b1;
    wt(100);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    wt(25);
    o_sda_low <= 1'b1;
    wt(75);
    o_scl <= 1'b1;
    wt(100);
    o_sda_low <= 1'b0;
    wt(100);
  endtask
  // byte msb first, then the ninth bit
  task automatic byte_io(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(a_in, r);
    ack = !r;
  endtask
  // pointer write, repeated start, two bytes read
  task automatic read2(input logic [7:0] ptr, output logic [15:0] q, output logic [2:0] acks);
    logic [7:0] x;
    start();
    byte_io({`CSR_DEV_ADDR, 1'b0}, 1'b1, x, acks[2]);
    byte_io(ptr, 1'b1, x, acks[1]);
    start();
    byte_io({`CSR_DEV_ADDR, 1'b1}, 1'b1, x, acks[0]);
    byte_io(8'hFF, 1'b0, q[15:8], x[0]);
    byte_io(8'hFF, 1'b1, q[7:0], x[0]);
    stop();
  endtask
  task automatic write1(input logic [7:0] ptr, input logic [7:0] d, output logic [2:0] acks);
    logic [7:0] x;
    start();
    byte_io({`CSR_DEV_ADDR, 1'b0}, 1'b1, x, acks[2]);
    byte_io(ptr, 1'b1, x, acks[1]);
    byte_io(d, 1'b1, x, acks[0]);
    stop();
  endtask
endmodule
`default_nettype wire

// ### verification/csr_top_properties.sv
// checker of the charger status bank ports
// assumes bind to csr_top; one clock domain
`timescale 1ns/1ns
`default_nettype none
module csr_top_properties (
  input wire logic i_clk, // core clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic o_sda_oe, // data drive enable
  input wire csr_pkg::csr_flags_t i_flags, // detector levels
  input wire csr_pkg::csr_summary_t i_summary, // charge state levels
  input wire logic [7:0] o_charger_flags, // flags copy
  input wire logic [7:0] o_charge_state_summary // summary copy
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic up;
  // ****
  // settle counter
  // ****
  // cycles since release, saturating at seven
  always_comb begin
    nxt_cnt = (cnt_ff == 3'h7) ? cnt_ff : cnt_ff + 3'h1;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign up = (cnt_ff == 3'h7);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ****
  // properties
  // ****
  property p_b7; up |-> o_charger_flags[7] == $past(i_flags[7], 3); endproperty
  a_b7: assert property (p_b7) else $error("current regulation flag wrong");
  property p_b6; up |-> o_charger_flags[6] == $past(i_flags[6], 3); endproperty
  a_b6: assert property (p_b6) else $error("voltage regulation flag wrong");
  property p_b5; up && $rose(i_flags[5]) |-> ##2 !o_charger_flags[5] ##1 o_charger_flags[5]; endproperty
  a_b5: assert property (p_b5) else $error("watchdog flag late or early");
  property p_b4; up && $fell(i_flags[4]) |-> ##2 o_charger_flags[4] ##1 !o_charger_flags[4]; endproperty
  a_b4: assert property (p_b4) else $error("weak adaptor flag late or early");
  property p_b3; up |-> o_charger_flags[3] == $past(i_flags[3], 3); endproperty
  a_b3: assert property (p_b3) else $error("power good flag wrong");
  property p_b2; up |-> o_charger_flags[2] == $past(i_flags[2], 3); endproperty
  a_b2: assert property (p_b2) else $error("second source flag wrong");
  property p_b1; up |-> o_charger_flags[1] == $past(i_flags[1], 3); endproperty
  a_b1: assert property (p_b1) else $error("first source flag wrong");
  property p_b0; up |-> o_charger_flags[0] == $past(i_flags[0], 3); endproperty
  a_b0: assert property (p_b0) else $error("bus supply flag wrong");
  property p_sum; up |-> o_charge_state_summary == $past(i_summary, 3); endproperty
  a_sum: assert property (p_sum) else $error("summary register wrong");
  property p_rst; disable iff (1'b0) !i_arst_n |-> o_charger_flags == 8'h00 && o_charge_state_summary == 8'h00 && !o_sda_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
endmodule
`default_nettype wire

// ### verification/csr_top_tb.sv
// self-checking bench of the charger status bank
// assumes csr_top, csr_host_model and the checker compiled before
`timescale 1ns/1ns
`default_nettype none
module csr_top_tb;
  logic clk, arst_n, scl, host_low, sda_o, sda_oe, sda;
  csr_pkg::csr_flags_t flags;
  csr_pkg::csr_summary_t summ;
  logic [7:0] o_fl, o_sm, m;
  logic [15:0] q;
  logic [2:0] a;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  // ****
  // clock, wire and instances
  // ****
  always #5 clk = ~clk;
  assign sda = !(sda_oe | host_low);
  csr_top dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_flags(flags), .i_summary(summ), .o_charger_flags(o_fl),
    .o_charge_state_summary(o_sm));
  csr_host_model host_u (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  // ****
  // checks and closing
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ****
  // test sequence
  // ****
  initial begin
    clk = 1'b0;
    arst_n = 1'b1;
    flags = 8'hFF;
    summ = 8'hFF;
    @(posedge clk) arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({o_fl, o_sm}, 16'h0000);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      m = 8'h01 << k;
      flags <= m;
      repeat (4) @(posedge clk);
      chk({8'h00, o_fl}, {8'h00, m});
      flags <= ~m;
      repeat (4) @(posedge clk);
      chk({8'h00, o_fl}, {8'h00, ~m});
    end
    summ <= 8'hA5;
    repeat (4) @(posedge clk);
    chk({8'h00, o_sm}, 16'h00A5);
    flags <= 8'hC9;
    summ <= 8'h37;
    host_u.read2(8'h1B, q, a);
    chk(q, 16'hC937);
    chk({15'h0000, sda_o}, 16'h0000);
    chk({13'h0, a}, 16'h0007);
    flags <= 8'h36;
    host_u.read2(8'h1B, q, a);
    chk(q, 16'h3637);
    host_u.write1(8'h1B, 8'hFF, a);
    chk({13'h0, a}, 16'h0007);
    host_u.read2(8'h1C, q, a);
    chk(q, 16'h3700);
    chk({8'h00, o_fl}, 16'h0036);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({o_fl, o_sm}, 16'h0000);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk({o_fl, o_sm}, 16'h3637);
    stop_test();
  end
endmodule
bind csr_top csr_top_properties chk_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .o_sda_oe(o_sda_oe), .i_flags(i_flags),
  .i_summary(i_summary), .o_charger_flags(o_charger_flags), .o_charge_state_summary(o_charge_state_summary));
`default_nettype wire
